// [design/dce_defs.vh]
/*
 Constants for the decrement/complement execution unit.
 Assumes a 14-bit instruction word and 8-bit file registers.
*/
`ifndef DCE_DEFS_VH
`define DCE_DEFS_VH

// Opcode field
`define DCE_OPC_MSB      13
`define DCE_OPC_LSB      8
`define DCE_OPC_DEC      6'h03
`define DCE_OPC_DECSKIP  6'h0B
`define DCE_OPC_COMP     6'h09
// Destination select bit and file address field
`define DCE_DEST_BIT     7
`define DCE_ADDR_MSB     6
`define DCE_ADDR_LSB     0
`define DCE_DEST_ACC     1'h0
// Quarter phases
`define DCE_Q1           2'h0
`define DCE_Q2           2'h1
`define DCE_Q3           2'h2
`define DCE_Q4           2'h3
// Reset values
`define DCE_ACC_RST      8'h00
`define DCE_ZERO_RST     1'h0
`define DCE_ADDR_RST     7'h00
`define DCE_DATA_RST     8'h00

`endif

// [design/dce_exec.v]
/*
 Execution unit for decrement, decrement-and-skip and complement of a file
 register, stepped through four quarter phases per instruction cycle.
 Assumes the fetch logic holds instr steady over an instruction cycle and
 the register file returns file_rdata, for file_addr, during the quarter
 after the read strobe file_rd.
 Assumes a write on file_wr lands at the clock edge that ends the pulse, so
 the read of the next instruction already sees it.
 Assumes the fetch logic steps the program address by two when it sees
 pc_advance_two, and that the word it offers during skip_cycle is dropped.
*/
`timescale 1ns/1ps
`include "dce_defs.vh"

module dce_exec
(
    // Clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // Instruction in
    input  wire [13:0] instr,
    // File register port
    output reg  [6:0]  file_addr,
    output wire        file_rd,
    input  wire [7:0]  file_rdata,
    output wire        file_wr,
    output reg  [7:0]  file_wdata,
    // Results and status
    output reg  [7:0]  acc,
    output reg         zero_flag,
    output wire [1:0]  quarter,
    output wire        cycle_end,
    output reg         skip_cycle,
    output wire        pc_advance_two,
    output reg         executing
);

    ////////////////////////////////////////////////////////////////////
    // Decoding
    localparam OP_NONE    = 2'h0;
    localparam OP_DEC     = 2'h1;
    localparam OP_DECSKIP = 2'h2;
    localparam OP_COMP    = 2'h3;

    function [1:0] decode_op;
        input [13:0] word;
        begin
            case (word[`DCE_OPC_MSB:`DCE_OPC_LSB])
                `DCE_OPC_DEC:     decode_op = OP_DEC;
                `DCE_OPC_DECSKIP: decode_op = OP_DECSKIP;
                `DCE_OPC_COMP:    decode_op = OP_COMP;
                default:          decode_op = OP_NONE;
            endcase
        end
    endfunction

    function is_zero;
        input [7:0] value;
        begin
            is_zero = (value == 8'h00);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Quarter phase counter
    reg  [1:0] phase;
    reg  [1:0] op;
    reg        dest;
    reg  [7:0] result;
    reg        skip_pending;
    reg        wr_q;
    wire [7:0] next_result;

    assign quarter   = phase;
    assign cycle_end = (phase == `DCE_Q4);

    always @(posedge core_clk)
    begin
        if (srst)
            phase <= `DCE_Q1;
        else
            phase <= phase + 2'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Bitwise complement and borrow chain of the decrement
    wire [7:0] comp_value;
    wire [7:0] dec_value;
    wire [7:0] borrow;
    wire       take_skip;

    // A borrow reaches a bit only while every lower bit is zero
    assign borrow[0] = 1'b1;

    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1)
        begin : g_alu_bit
            assign comp_value[bit_idx] = ~file_rdata[bit_idx];
            assign dec_value[bit_idx]  = file_rdata[bit_idx] ^ borrow[bit_idx];
            if (bit_idx < 7)
            begin : g_borrow
                assign borrow[bit_idx + 1] = borrow[bit_idx] & ~file_rdata[bit_idx];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Datapath
    assign next_result    = (op == OP_COMP) ? comp_value : dec_value;
    assign file_rd        = executing && (phase == `DCE_Q2);
    assign file_wr        = wr_q;
    assign take_skip      = executing && (op == OP_DECSKIP) && is_zero(result);
    assign pc_advance_two = cycle_end && take_skip;

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            op         <= OP_NONE;
            dest       <= `DCE_DEST_ACC;
            file_addr  <= `DCE_ADDR_RST;
            result     <= `DCE_DATA_RST;
            file_wdata <= `DCE_DATA_RST;
            acc        <= `DCE_ACC_RST;
            executing  <= 1'b0;
            wr_q       <= 1'b0;
        end
        else
        begin
            wr_q <= 1'b0;
            case (phase)
                `DCE_Q1:
                begin
                    // Decode, unless this cycle is the forced nop
                    if (skip_pending)
                    begin
                        op        <= OP_NONE;
                        executing <= 1'b0;
                    end
                    else
                    begin
                        op        <= decode_op(instr);
                        executing <= (decode_op(instr) != OP_NONE);
                        dest      <= instr[`DCE_DEST_BIT];
                        file_addr <= instr[`DCE_ADDR_MSB:`DCE_ADDR_LSB];
                    end
                end
                `DCE_Q2:
                begin
                    // Read issued combinationally this quarter
                end
                `DCE_Q3:
                begin
                    if (executing)
                        result <= next_result;
                end
                `DCE_Q4:
                begin
                    if (executing)
                    begin
                        if (dest == `DCE_DEST_ACC)
                            acc <= result;
                        else
                        begin
                            file_wdata <= result;
                            wr_q       <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    wr_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Zero flag; decrement-and-skip leaves it alone
    always @(posedge core_clk)
    begin
        if (srst)
            zero_flag <= `DCE_ZERO_RST;
        else if ((phase == `DCE_Q4) && executing && (op != OP_DECSKIP))
            zero_flag <= is_zero(result);
    end

    ////////////////////////////////////////////////////////////////////
    // Skip control; a zero decrement-and-skip turns the next cycle into a nop
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            skip_pending <= 1'b0;
            skip_cycle   <= 1'b0;
        end
        else if (phase == `DCE_Q1)
        begin
            skip_cycle   <= skip_pending;
            skip_pending <= 1'b0;
        end
        else if ((phase == `DCE_Q4) && take_skip)
        begin
            skip_pending <= 1'b1;
        end
    end

endmodule

// [verif/dce_exec_chk.sv]
/* Checker for dce_exec. Assumes it is bound to the top module's ports. */
`timescale 1ns/1ps
module dce_chk
(
    // Clock and reset
    input wire        core_clk,
    input wire        srst,
    // Instruction and file register port
    input wire [13:0] instr,
    input wire [6:0]  file_addr,
    input wire        file_rd,
    input wire [7:0]  file_rdata,
    input wire        file_wr,
    input wire [7:0]  file_wdata,
    // Results and status
    input wire [7:0]  acc,
    input wire        zero_flag,
    input wire [1:0]  quarter,
    input wire        cycle_end,
    input wire        skip_cycle,
    input wire        pc_advance_two,
    input wire        executing
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire [5:0] opc = instr[13:8];
    wire       q2  = quarter == 2'h2 && !skip_cycle;
    property p_seq; !$past(srst) |-> quarter == $past(quarter) + 2'h1; endproperty
    property p_rd; file_rd |-> quarter == 2'h1; endproperty
    property p_wr; file_wr |-> quarter == 2'h0 && $past(quarter) == 2'h3; endproperty
    property p_pc2; pc_advance_two |-> cycle_end ##2 skip_cycle [*4]; endproperty
    property p_nop; skip_cycle && quarter == 2'h1 |-> !file_rd; endproperty
    property p_acc; !$stable(acc) |-> $past(quarter) == 2'h3; endproperty
    property p_dec;
        q2 && opc == 6'h03 |=> ##1 zero_flag == ($past(file_rdata, 2) == 8'h01) &&
        ($past(instr[7], 2) ? file_wr && file_addr == $past(instr[6:0], 2) &&
        file_wdata == $past(file_rdata, 2) - 8'h01 : acc == $past(file_rdata, 2) - 8'h01);
    endproperty
    property p_comp;
        q2 && opc == 6'h09 && !instr[7] |=> ##1 acc == ~$past(file_rdata, 2) &&
        zero_flag == ($past(file_rdata, 2) == 8'hFF);
    endproperty
    property p_compw;
        q2 && opc == 6'h09 && instr[7] |=> ##1 file_wr && file_addr == $past(instr[6:0], 2) &&
        file_wdata == ~$past(file_rdata, 2) && zero_flag == ($past(file_rdata, 2) == 8'hFF);
    endproperty
    property p_exe;
        quarter == 2'h1 |-> executing == (!skip_cycle && (opc == 6'h03 || opc == 6'h0B ||
        opc == 6'h09));
    endproperty
    property p_skz; q2 && opc == 6'h0B |=> pc_advance_two == ($past(file_rdata) == 8'h01);
    endproperty
    a_seq: assert property (p_seq) else $error("quarter order");
    a_rd: assert property (p_rd) else $error("read outside Q2");
    a_wr: assert property (p_wr) else $error("write timing");
    a_pc2: assert property (p_pc2) else $error("skip cycle");
    a_nop: assert property (p_nop) else $error("read in nop");
    a_acc: assert property (p_acc) else $error("acc timing");
    a_dec: assert property (p_dec) else $error("decrement");
    a_comp: assert property (p_comp) else $error("complement");
    a_skz: assert property (p_skz) else $error("skip decision");
    a_compw: assert property (p_compw) else $error("complement write back");
    a_exe: assert property (p_exe) else $error("decode enable");
    c_skip: cover property (pc_advance_two);
    c_wr: cover property (file_wr);
    c_comp: cover property (q2 && opc == 6'h09);
    c_nop: cover property (skip_cycle && quarter == 2'h1);
endmodule
bind dce_exec dce_chk i_chk (.core_clk(core_clk), .srst(srst), .file_rd(file_rd),
    .file_wr(file_wr), .zero_flag(zero_flag), .cycle_end(cycle_end), .skip_cycle(skip_cycle),
    .pc_advance_two(pc_advance_two), .instr(instr), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .acc(acc), .quarter(quarter),
    .executing(executing));

// [verif/dce_exec_tb.sv]
/* Testbench for dce_exec. Assumes a file register model kept here. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module decrement_complement_exec_tb_top;
    reg        core_clk = 1'b0;
    reg        srst = 1'b1;
    reg [13:0] instr = 14'h0000;
    reg [7:0]  mem [0:127];
    integer    n_mismatch = 0, total_checks = 0;
    wire [6:0] file_addr;
    wire [7:0] file_wdata, acc;
    wire [1:0] quarter;
    wire       file_wr, zero_flag, skip_cycle, executing;
    wire [7:0] file_rdata = mem[file_addr];
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (file_wr) mem[file_addr] <= file_wdata;
    dce_exec i_dut (.core_clk(core_clk), .srst(srst), .instr(instr), .file_addr(file_addr),
        .file_rd(), .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
        .acc(acc), .zero_flag(zero_flag), .quarter(quarter), .cycle_end(),
        .skip_cycle(skip_cycle), .pc_advance_two(), .executing(executing));
    task op(input [13:0] w);
    begin
        while (quarter !== 2'h0) @(posedge core_clk) #1;
        instr = w;
        repeat (4) @(posedge core_clk);
        #1;
    end
    endtask
    task conclude;
    begin
        if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
    endtask
    task t_dec;
    begin
        mem[5] = 8'h01;
        mem[6] = 8'h80;
        mem[127] = 8'h00;
        op(14'h0306);
        `CHK("acc", 8'h7F, acc)
        `CHK("zero", 1'b0, zero_flag)
        op(14'h0305);
        `CHK("acc", 8'h00, acc)
        `CHK("zero", 1'b1, zero_flag)
        op(14'h03FF);
        `CHK("zero", 1'b0, zero_flag)
        `CHK("acc", 8'h00, acc)
        op(14'h0000);
        `CHK("exec", 1'b0, executing)
        `CHK("f7F", 8'hFF, mem[127])
        `CHK("f05", 8'h01, mem[5])
    end
    endtask
    task t_comp;
    begin
        mem[0] = 8'h13;
        mem[1] = 8'hFF;
        op(14'h0900);
        `CHK("acc", 8'hEC, acc)
        `CHK("exec", 1'b1, executing)
        op(14'h0981);
        `CHK("zero", 1'b1, zero_flag)
        `CHK("acc", 8'hEC, acc)
        op(14'h0000);
        `CHK("f00", 8'h13, mem[0])
        `CHK("f01", 8'h00, mem[1])
    end
    endtask
    task t_skip;
    begin
        mem[2] = 8'h02;
        mem[3] = 8'h09;
        op(14'h0B82);
        `CHK("zero", 1'b1, zero_flag)
        op(14'h0B82);
        op(14'h0383);
        `CHK("skip", 1'b1, skip_cycle)
        `CHK("exec", 1'b0, executing)
        op(14'h0000);
        `CHK("f03", 8'h09, mem[3])
        `CHK("f02", 8'h00, mem[2])
    end
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk);
        #1 srst = 1'b0;
        t_dec;
        t_comp;
        t_skip;
        conclude;
    end
    initial
    begin
        #4000;
        n_mismatch++;
        conclude;
    end
endmodule
